/* File: rtl/aip_pkg.sv */
// Purpose: Constants and types for the analog input parameter bank
// Assumes: Byte-wide parameter port addressed by object index, subindex or record set
// Notes: One package shared by the bank and the bench
package aip_pkg;
    localparam int CHANNELS = 4;
    localparam int PARAM_BYTES = 28;
    localparam logic [15:0] OBJECT_INDEX_BASE = 16'h3100;
    localparam logic [15:0] OBJECT_INDEX_LAST = 16'h311B;
    localparam logic [7:0] SUBINDEX_FIRST = 8'h01;
    localparam logic [7:0] SUBINDEX_LAST = 8'h14;
    // Byte positions inside the parameter image
    localparam logic [4:0] POS_DIAG = 5'h00;
    localparam logic [4:0] POS_RES_A = 5'h01;
    localparam logic [4:0] POS_LIMIT_EN = 5'h02;
    localparam logic [4:0] POS_MAINS = 5'h03;
    localparam logic [4:0] POS_CH_BASE = 5'h04;
    localparam logic [4:0] CH_STRIDE = 5'h06;
    localparam logic [2:0] OFS_RANGE = 3'h0;
    localparam logic [2:0] OFS_RES = 3'h1;
    localparam logic [2:0] OFS_HIGH = 3'h2;
    localparam logic [2:0] OFS_LOW = 3'h4;
    // Record set numbers
    localparam logic [7:0] SET_GLOBAL = 8'h00;
    localparam logic [7:0] SET_MAINS = 8'h01;
    localparam logic [7:0] SET_CH_FIRST = 8'h80;
    localparam logic [7:0] SET_CH_LAST = 8'h83;
    // Reset values and codes
    localparam logic [7:0] DIAG_OFF = 8'h00;
    localparam logic [7:0] DIAG_ON = 8'h40;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] RANGE_RESET = 8'h10;
    localparam logic [7:0] RANGE_OFF = 8'hFF;
    localparam logic [7:0] RANGE_27648 = 8'h10;
    localparam logic [7:0] RANGE_16384 = 8'h20;
    localparam logic [15:0] HIGH_RESET = 16'h7FFF;
    localparam logic [15:0] LOW_RESET = 16'h8000;
    localparam logic signed [15:0] NOMINAL_27648 = 16'sh6C00;
    localparam logic signed [15:0] NOMINAL_16384 = 16'sh4000;
    localparam logic [3:0] LIMIT_EN_MASK = 4'hF;

    typedef enum logic [1:0] {
        REJECT_NONE = 2'b00,
        REJECT_60HZ = 2'b01,
        REJECT_50HZ = 2'b10,
        REJECT_BAD = 2'b11
    } mains_rejection_e;

    // Addressing modes of the parameter port
    typedef enum logic [1:0] {
        MODE_INDEX = 2'b00,
        MODE_SUBINDEX = 2'b01,
        MODE_RECORD = 2'b11
    } access_mode_e;

    typedef struct packed {
        logic valid;
        logic write;
        access_mode_e mode;
        logic [15:0] object_index;
        logic [7:0] object_subindex;
        logic [7:0] record_set_number;
        logic [1:0] record_byte;
        logic [7:0] wdata;
    } param_req_s;

    typedef struct packed {
        logic [15:0] high_limit;
        logic [15:0] low_limit;
        logic [7:0] range_code;
        mains_rejection_e rejection;
        logic monitor;
        logic active;
    } channel_cfg_s;
endpackage

/* File: rtl/analog_input_param_bank.sv */
// Purpose: Parameter record bank of a four-channel 16-bit voltage input module
// Assumes: One byte access per request, answered in the same cycle (rdata next cycle)
// Notes: Limits wider than one byte are addressed byte by byte, high byte first, by index; subindex and record access reach only the high byte

module analog_input_param_bank (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire aip_pkg::param_req_s req,
    output logic req_ack,
    output logic req_error,
    output logic [7:0] rdata,
    input wire logic [15:0] sample [aip_pkg::CHANNELS],
    input wire logic sample_strobe,
    input wire logic [2:0] input_offset,
    output logic [7:0] input_byte,
    output aip_pkg::channel_cfg_s channel_cfg [aip_pkg::CHANNELS],
    output logic diag_irq_enable,
    output logic [1:0] mains_rejection [aip_pkg::CHANNELS],
    output logic [3:0] limit_over,
    output logic [3:0] limit_under,
    output logic [3:0] process_irq,
    output logic param_error
);
    // ------------------------------------------------------------
    // Parameter image
    // ------------------------------------------------------------
    logic [7:0] image [aip_pkg::PARAM_BYTES];
    logic [15:0] result [aip_pkg::CHANNELS];
    logic [4:0] pos;
    logic pos_ok;
    logic [3:0] prev_out;
    logic [3:0] over_now;
    logic [3:0] under_now;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Byte position of a field inside a channel record
    function automatic logic [4:0] chan_pos(input logic [4:0] ch, input logic [4:0] ofs);
        chan_pos = aip_pkg::POS_CH_BASE + 5'(ch * aip_pkg::CH_STRIDE) + ofs;
    endfunction

    // Field offset of a record byte: range, reserved, high limit, low limit
    function automatic logic [4:0] rec_to_ofs(input logic [1:0] b);
        case (b)
            2'd0: begin
                rec_to_ofs = 5'(aip_pkg::OFS_RANGE);
            end
            2'd1: begin
                rec_to_ofs = 5'(aip_pkg::OFS_RES);
            end
            2'd2: begin
                rec_to_ofs = 5'(aip_pkg::OFS_HIGH);
            end
            default: begin
                rec_to_ofs = 5'(aip_pkg::OFS_LOW);
            end
        endcase
    endfunction

    // Byte position of a subindex (01h..14h); a limit subindex names its high byte
    function automatic logic [4:0] sub_to_pos(input logic [7:0] sub);
        logic [4:0] s;
        logic [4:0] ch;
        logic [1:0] k;
        s = sub[4:0] - 5'd1;
        ch = (s - 5'd4) >> 2;
        k = 2'(s - 5'd4);
        if (s < 5'd4) begin
            sub_to_pos = s;
        end else begin
            sub_to_pos = chan_pos(ch, rec_to_ofs(k));
        end
    endfunction

    // Reserved bytes: one in set 00h and one in each channel record
    function automatic logic is_reserved(input logic [4:0] p);
        is_reserved = (p == aip_pkg::POS_RES_A);
        for (int c = 0; c < aip_pkg::CHANNELS; c++) begin
            if (p == chan_pos(5'(c), 5'(aip_pkg::OFS_RES))) begin
                is_reserved = 1'b1;
            end
        end
    endfunction

    // Nominal full scale of a range code
    function automatic logic signed [15:0] nominal_of(input logic [7:0] code);
        if (code == aip_pkg::RANGE_16384) begin
            nominal_of = aip_pkg::NOMINAL_16384;
        end else begin
            nominal_of = aip_pkg::NOMINAL_27648;
        end
    endfunction

    // Upper limit inside the nominal range, or 7FFFh to switch it off
    function automatic logic high_limit_ok(input logic [15:0] v, input logic [7:0] code);
        high_limit_ok = (v == aip_pkg::HIGH_RESET)
            || ($signed(v) >= 16'sh0000 && $signed(v) <= nominal_of(code));
    endfunction

    // Lower limit inside the nominal range, or 8000h to switch it off
    function automatic logic low_limit_ok(input logic [15:0] v, input logic [7:0] code);
        low_limit_ok = (v == aip_pkg::LOW_RESET)
            || ($signed(v) >= 16'sh0000 && $signed(v) <= nominal_of(code));
    endfunction

    function automatic logic [15:0] word_at(input logic [4:0] p);
        word_at = {image[p], image[p + 5'd1]};
    endfunction

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    always_comb begin
        pos = 5'd0;
        pos_ok = 1'b0;
        case (req.mode)
            aip_pkg::MODE_INDEX: begin
                if (req.object_index >= aip_pkg::OBJECT_INDEX_BASE && req.object_index <= aip_pkg::OBJECT_INDEX_LAST) begin
                    pos = 5'(req.object_index - aip_pkg::OBJECT_INDEX_BASE);
                    pos_ok = 1'b1;
                end
            end
            aip_pkg::MODE_SUBINDEX: begin
                if (req.object_subindex >= aip_pkg::SUBINDEX_FIRST && req.object_subindex <= aip_pkg::SUBINDEX_LAST) begin
                    pos = sub_to_pos(req.object_subindex);
                    pos_ok = 1'b1;
                end
            end
            aip_pkg::MODE_RECORD: begin
                if (req.record_set_number == aip_pkg::SET_GLOBAL && req.record_byte != 2'd3) begin
                    pos = 5'(req.record_byte);
                    pos_ok = 1'b1;
                end else if (req.record_set_number == aip_pkg::SET_MAINS && req.record_byte == 2'd0) begin
                    pos = aip_pkg::POS_MAINS;
                    pos_ok = 1'b1;
                end else if (req.record_set_number >= aip_pkg::SET_CH_FIRST
                             && req.record_set_number <= aip_pkg::SET_CH_LAST) begin
                    // Record byte selects range, reserved, high limit, low limit fields
                    pos = chan_pos(5'(req.record_set_number[1:0]), rec_to_ofs(req.record_byte));
                    pos_ok = 1'b1;
                end
            end
            default: begin
                pos_ok = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Handshake
    // ------------------------------------------------------------
    assign req_ack = req.valid & pos_ok;
    assign req_error = req.valid & ~pos_ok;

    // ------------------------------------------------------------
    // Writes
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < aip_pkg::PARAM_BYTES; i++) begin
                image[i] <= aip_pkg::RESET_BYTE;
            end
            for (int c = 0; c < aip_pkg::CHANNELS; c++) begin
                image[4 + c * 6] <= aip_pkg::RANGE_RESET;
                image[6 + c * 6] <= aip_pkg::HIGH_RESET[15:8];
                image[7 + c * 6] <= aip_pkg::HIGH_RESET[7:0];
                image[8 + c * 6] <= aip_pkg::LOW_RESET[15:8];
                image[9 + c * 6] <= aip_pkg::LOW_RESET[7:0];
            end
        end else if (req.valid && req.write && pos_ok) begin
            // Host is expected to write set 00h only while the controller is stopped
            case (pos)
                aip_pkg::POS_DIAG: begin
                    image[pos] <= req.wdata;
                end
                aip_pkg::POS_LIMIT_EN: begin
                    image[pos] <= {4'h0, req.wdata[3:0] & aip_pkg::LIMIT_EN_MASK};
                end
                aip_pkg::POS_MAINS: begin
                    image[pos] <= req.wdata;
                end
                default: begin
                    if (pos >= aip_pkg::POS_CH_BASE && !is_reserved(pos)) begin
                        image[pos] <= req.wdata;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else if (req.valid && !req.write && pos_ok) begin
            rdata <= is_reserved(pos) ? 8'h00 : image[pos];
        end
    end

    // ------------------------------------------------------------
    // Decoded configuration and checks
    // ------------------------------------------------------------
    assign diag_irq_enable = (image[aip_pkg::POS_DIAG] == aip_pkg::DIAG_ON);

    always_comb begin
        for (int c = 0; c < aip_pkg::CHANNELS; c++) begin
            mains_rejection[c] = image[aip_pkg::POS_MAINS][2 * c +: 2];
            channel_cfg[c].rejection = aip_pkg::mains_rejection_e'(image[aip_pkg::POS_MAINS][2 * c +: 2]);
            channel_cfg[c].monitor = image[aip_pkg::POS_LIMIT_EN][c];
            channel_cfg[c].range_code = image[4 + c * 6];
            channel_cfg[c].active = (image[4 + c * 6] != aip_pkg::RANGE_OFF);
            channel_cfg[c].high_limit = word_at(5'(6 + c * 6));
            channel_cfg[c].low_limit = word_at(5'(8 + c * 6));
        end
    end

    // ------------------------------------------------------------
    // Parameterization check
    // ------------------------------------------------------------
    always_comb begin
        param_error = ~(image[aip_pkg::POS_DIAG] == aip_pkg::DIAG_OFF || image[aip_pkg::POS_DIAG] == aip_pkg::DIAG_ON);
        for (int c = 0; c < aip_pkg::CHANNELS; c++) begin
            if (image[aip_pkg::POS_MAINS][2 * c +: 2] == aip_pkg::REJECT_BAD) begin
                param_error = 1'b1;
            end
            if (image[4 + c * 6] != aip_pkg::RANGE_OFF && image[4 + c * 6] != aip_pkg::RANGE_27648
                && image[4 + c * 6] != aip_pkg::RANGE_16384) begin
                param_error = 1'b1;
            end
            if (!high_limit_ok(word_at(5'(6 + c * 6)), image[4 + c * 6])
                || !low_limit_ok(word_at(5'(8 + c * 6)), image[4 + c * 6])) begin
                param_error = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Conversion results and limit monitoring
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int c = 0; c < aip_pkg::CHANNELS; c++) begin
                result[c] <= 16'h0000;
            end
        end else if (sample_strobe) begin
            for (int c = 0; c < aip_pkg::CHANNELS; c++) begin
                result[c] <= channel_cfg[c].active ? sample[c] : 16'h0000;
            end
        end
    end

    // Input area: channel n high byte at offset 2n, low byte at 2n+1
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            input_byte <= 8'h00;
        end else if (input_offset[0]) begin
            input_byte <= result[input_offset[2:1]][7:0];
        end else begin
            input_byte <= result[input_offset[2:1]][15:8];
        end
    end

    // ------------------------------------------------------------
    // Limit window
    // ------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < aip_pkg::CHANNELS; c++) begin
            over_now[c] = channel_cfg[c].monitor && channel_cfg[c].active
                && channel_cfg[c].high_limit != aip_pkg::HIGH_RESET
                && $signed(result[c]) > $signed(channel_cfg[c].high_limit);
            under_now[c] = channel_cfg[c].monitor && channel_cfg[c].active
                && channel_cfg[c].low_limit != aip_pkg::LOW_RESET
                && $signed(result[c]) < $signed(channel_cfg[c].low_limit);
        end
    end

    // Limit flags
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            limit_over <= 4'h0;
            limit_under <= 4'h0;
        end else begin
            limit_over <= over_now;
            limit_under <= under_now;
        end
    end

    // Window state of the previous cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prev_out <= 4'h0;
        end else begin
            prev_out <= over_now | under_now;
        end
    end

    // One-cycle interrupt pulse on leaving the window
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            process_irq <= 4'h0;
        end else begin
            process_irq <= (over_now | under_now) & ~prev_out;
        end
    end
endmodule

/* File: sim/coupler_model.sv */
// Purpose: Host side model that reads and writes parameter bytes
// Assumes: One byte per call, request held until the taking edge
// Notes: Address a is index, subindex in a[7:0], or set in a[15:8] with byte in a[1:0]
module coupler_model (
    input wire logic sys_clk,
    input wire logic stopped,
    output aip_pkg::param_req_s req,
    input wire logic req_ack,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req = '0;
    task automatic access(input aip_pkg::access_mode_e m, input logic [15:0] a, input logic wr,
        input logic [7:0] wd, output logic ok, output logic [7:0] rd);
        logic glob;
        glob = wr && (m == aip_pkg::MODE_INDEX ? a <= 16'h3102 : m == aip_pkg::MODE_SUBINDEX ?
            a[7:0] <= 8'h03 : a[15:8] == 8'h00);
        @(posedge sys_clk);
        while (glob && !stopped) @(posedge sys_clk);
        #1 req = '{1'h1, wr, m, a, a[7:0], a[15:8], a[1:0], wd};
        @(posedge sys_clk);
        ok = req_ack;
        #1 req.valid = 1'h0;
        req.wdata = ~wd;
        rd = rdata;
    endtask
endmodule

/* File: sim/param_bank_chk.sv */
// Purpose: Port level assertions for the parameter bank
// Assumes: One clock, asynchronous active low reset
// Notes: Bound into the bank below
module param_bank_chk (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire aip_pkg::param_req_s req,
    input wire logic req_ack,
    input wire logic req_error,
    input wire logic [7:0] rdata,
    input wire aip_pkg::channel_cfg_s channel_cfg [aip_pkg::CHANNELS],
    input wire logic diag_irq_enable,
    input wire logic [1:0] mains_rejection [aip_pkg::CHANNELS],
    input wire logic [3:0] process_irq
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    logic iw;
    assign iw = req.valid && req.write && req.mode == aip_pkg::MODE_INDEX;
    chk_index_span: assert property (req.valid && req.mode == aip_pkg::MODE_INDEX |->
        req_ack == (req.object_index >= 16'h3100 && req.object_index <= 16'h311B) && req_error != req_ack)
        else $error("index decode wrong");
    chk_subindex_span: assert property (req.valid && req.mode == aip_pkg::MODE_SUBINDEX |->
        req_ack == (req.object_subindex >= 8'h01 && req.object_subindex <= 8'h14) && req_error != req_ack)
        else $error("subindex decode wrong");
    chk_idle_quiet: assert property (!req.valid |-> !req_ack && !req_error)
        else $error("answer without request");
    chk_diag_write: assert property (iw && req.object_index == 16'h3100 |=>
        diag_irq_enable == ($past(req.wdata) == 8'h40)) else $error("diag enable wrong");
    chk_mains_fields: assert property (iw && req.object_index == 16'h3103 |=>
        mains_rejection[0] == $past(req.wdata[1:0]) && mains_rejection[3] == $past(req.wdata[7:6]))
        else $error("suppression field wrong");
    chk_monitor_bits: assert property (iw && req.object_index == 16'h3102 |=>
        channel_cfg[0].monitor == $past(req.wdata[0]) && channel_cfg[3].monitor == $past(req.wdata[3]))
        else $error("monitor enable wrong");
    chk_reserved_zero: assert property (req.valid && !req.write && req_ack &&
        req.mode == aip_pkg::MODE_INDEX && req.object_index == 16'h3105 |=> rdata == 8'h00)
        else $error("reserved byte not zero");
    chk_error_holds: assert property (req.valid && !req.write && req_error |=> $stable(rdata))
        else $error("rdata moved on refused read");
    chk_reset_image: assert property ($rose(rstn) |-> channel_cfg[0].high_limit == 16'h7FFF &&
        channel_cfg[0].low_limit == 16'h8000 && channel_cfg[0].range_code == 8'h10)
        else $error("image not at defaults");
    chk_irq_pulse: assert property (process_irq[0] |-> channel_cfg[0].monitor ##1 !process_irq[0])
        else $error("interrupt pulse wrong");
    cov_write: cover property (iw && req_ack);
    cov_refuse: cover property (req_error);
    cov_irq: cover property (process_irq[0]);
endmodule
bind analog_input_param_bank param_bank_chk chk_u (.sys_clk, .rstn, .req, .req_ack, .req_error, .rdata,
    .channel_cfg, .diag_irq_enable, .mains_rejection, .process_irq);

/* File: sim/tb.sv */
// Purpose: Self-checking bench for the parameter bank
// Assumes: 100 MHz clock, inputs driven 1 ns after the rising edge
// Notes: Host accesses go through the coupler model
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rstn, stopped, sample_strobe, req_ack, req_error, param_error, diag_irq_enable, ok;
    aip_pkg::param_req_s req;
    logic [7:0] rdata, input_byte, rd;
    logic [15:0] sample [aip_pkg::CHANNELS];
    logic [2:0] input_offset;
    aip_pkg::channel_cfg_s channel_cfg [aip_pkg::CHANNELS];
    logic [1:0] mains_rejection [aip_pkg::CHANNELS];
    logic [3:0] limit_over, limit_under, process_irq;
    logic [7:0] mains_rejection_select [4] = '{8'hAA, 8'h55, 8'hE4, 8'h00};
    int n_fail = 0;
    int cmp_count = 0;
    analog_input_param_bank dut_u (.sys_clk, .rstn, .req, .req_ack, .req_error, .rdata, .sample,
        .sample_strobe, .input_offset, .input_byte, .channel_cfg, .diag_irq_enable, .mains_rejection,
        .limit_over, .limit_under, .process_irq, .param_error);
    coupler_model host_u (.sys_clk, .stopped, .req, .req_ack, .rdata);
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(input aip_pkg::access_mode_e m, input logic [15:0] a, input logic wr, input logic [7:0] wd);
        host_u.access(m, a, wr, wd, ok, rd);
    endtask
    task automatic rdc(input aip_pkg::access_mode_e m, input logic [15:0] a, input logic [7:0] exp);
        acc(m, a, 1'h0, 8'h00);
        chk("ack", 16'h0001, {15'h0, ok});
        chk("rdata", {8'h00, exp}, {8'h00, rd});
    endtask
    function automatic logic [7:0] rst_byte(input int i);
        if (i < 4) return 8'h00;
        case ((i - 4) % 6)
            0: return 8'h10;
            2: return 8'h7F;
            3: return 8'hFF;
            4: return 8'h80;
            default: return 8'h00;
        endcase
    endfunction
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Whole run is about 200 cycles, so 20 us means a hang
    initial begin
        #20us;
        n_fail++;
        conclude();
    end
    initial #1500 stopped = 1'h1;
    initial begin
        rstn = 1'h0;
        stopped = 1'h0;
        sample_strobe = 1'h0;
        input_offset = 3'h0;
        sample = '{16'h1234, 16'h0BCD, 16'h2A3B, 16'h6C00};
        repeat (10) @(posedge sys_clk);
        #1 rstn = 1'h1;
        for (int i = 0; i < 28; i++) rdc(aip_pkg::MODE_INDEX, 16'h3100 + 16'(i), rst_byte(i));
        sample_strobe = 1'h1;
        @(posedge sys_clk);
        #1 sample_strobe = 1'h0;
        for (int o = 0; o < 8; o++) begin
            input_offset = o[2:0];
            repeat (2) @(posedge sys_clk);
            #1 chk("input", {8'h00, o[0] ? sample[o / 2][7:0] : sample[o / 2][15:8]}, {8'h00, input_byte});
        end
        acc(aip_pkg::MODE_INDEX, 16'h3100, 1'h1, 8'h40);
        chk("diag", 16'h0001, {15'h0, diag_irq_enable});
        acc(aip_pkg::MODE_INDEX, 16'h3100, 1'h1, 8'h00);
        chk("diag", 16'h0000, {15'h0, diag_irq_enable});
        acc(aip_pkg::MODE_INDEX, 16'h3102, 1'h1, 8'hFF);
        rdc(aip_pkg::MODE_INDEX, 16'h3102, 8'h0F);
        for (int k = 0; k < 4; k++) chk("monitor", 16'h0001, {15'h0, channel_cfg[k].monitor});
        for (int s = 0; s < 4; s++) begin
            acc(aip_pkg::MODE_INDEX, 16'h3103, 1'h1, mains_rejection_select[s]);
            for (int k = 0; k < 4; k++) chk("mains", {14'h0, mains_rejection_select[s][2 * k +: 2]}, {14'h0, mains_rejection[k]});
            chk("param error", {15'h0, mains_rejection_select[s] == 8'hE4}, {15'h0, param_error});
        end
        acc(aip_pkg::MODE_INDEX, 16'h3105, 1'h1, 8'hFF);
        rdc(aip_pkg::MODE_INDEX, 16'h3105, 8'h00);
        acc(aip_pkg::MODE_INDEX, 16'h3106, 1'h1, 8'h10);
        acc(aip_pkg::MODE_INDEX, 16'h3107, 1'h1, 8'h00);
        chk("high limit", 16'h1000, channel_cfg[0].high_limit);
        acc(aip_pkg::MODE_INDEX, 16'h311C, 1'h0, 8'h00);
        chk("ack", 16'h0000, {15'h0, ok});
        rdc(aip_pkg::MODE_SUBINDEX, 16'h0011, 8'h10);
        rdc(aip_pkg::MODE_SUBINDEX, 16'h0007, 8'h10);
        rdc(aip_pkg::MODE_RECORD, 16'h8002, 8'h10);
        acc(aip_pkg::MODE_SUBINDEX, 16'h000D, 1'h1, 8'h20);
        chk("range", 16'h0020, {8'h00, channel_cfg[2].range_code});
        acc(aip_pkg::MODE_SUBINDEX, 16'h0015, 1'h0, 8'h00);
        chk("ack", 16'h0000, {15'h0, ok});
        acc(aip_pkg::MODE_RECORD, 16'h8300, 1'h1, 8'hFF);
        chk("active", 16'h0000, {15'h0, channel_cfg[3].active});
        rdc(aip_pkg::MODE_RECORD, 16'h0002, 8'h0F);
        acc(aip_pkg::MODE_RECORD, 16'h0200, 1'h0, 8'h00);
        chk("ack", 16'h0000, {15'h0, ok});
        acc(aip_pkg::MODE_INDEX, 16'h3102, 1'h1, 8'h00);
        acc(aip_pkg::MODE_INDEX, 16'h3102, 1'h1, 8'h01);
        sample_strobe = 1'h1;
        @(posedge sys_clk);
        #1 sample_strobe = 1'h0;
        chk("irq", 16'h0001, {12'h0, process_irq});
        repeat (3) @(posedge sys_clk);
        #1 chk("over", 16'h0001, {12'h0, limit_over});
        chk("under", 16'h0000, {12'h0, limit_under});
        chk("irq", 16'h0000, {12'h0, process_irq});
        conclude();
    end
endmodule
